/* File: rtl/sar_adc_pkg.sv */
// Shared constants and types of the converter control logic.
// Assumes a 32-bit APB bus with word-aligned register slots.
package sar_adc_pkg;
  localparam int RESULT_BITS   = 12;
  localparam int CONV_CYCLES   = 60;
  localparam int CONV_CLK_DIV  = 4;
  localparam int TRIG_SOURCES  = 8;
  localparam int ADDR_W        = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h9A;
  localparam logic [7:0] IDX_SHARED  = 8'h9B;
  localparam logic [7:0] IDX_LOW     = 8'h9C;

  localparam logic [7:0] CONTROL_RESET = 8'h8F;
  localparam logic [7:0] CONFIG_RESET  = 8'h01;
  localparam logic [7:0] RESULT_RESET  = 8'h00;

  // Control register fields
  localparam int CTL_STANDBY = 7;
  localparam int CTL_GO      = 6;
  localparam int CTL_REF     = 5;
  localparam int CTL_DONE    = 4;
  localparam int CTL_CH_LSB  = 0;

  // Second config register fields
  localparam int CFG_HWTRIG  = 7;
  localparam int CFG_TSEL    = 4;
  localparam int CFG_ALIGN   = 2;

  localparam logic [3:0] CH_INTERNAL_1V8 = 4'hF;

  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_SAMPLE = 2'b01,
    SEQ_DECIDE = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic        powerDown;
    logic        referenceSelect;
    logic        inputEnable;
    logic [3:0]  channelSelect;
    logic        sampling;
    logic [11:0] dacCode;
  } analog_ctrl_t;
endpackage

/* File: rtl/sar_sequencer.sv */
// Successive-approximation sequencer: sample phase, then one bit per tick.
// Assumes tick pulses one clock wide and a comparator level on its clock.
`timescale 1ns/10ps
`default_nettype none
module sar_sequencer #(
  parameter int BITS   = 12,
  parameter int CYCLES = 60
) (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            rst_n,
  // Control
  input  wire logic            tick,
  input  wire logic            start,
  input  wire logic            abort,
  input  wire logic            compHigh,
  // Status
  output logic                 busy,
  output logic                 sampling,
  output logic                 done,
  output logic [BITS-1:0]      result,
  output logic [BITS-1:0]      dacCode
);
  import sar_adc_pkg::*;

  localparam logic [5:0] SAMPLE_LAST = 6'(CYCLES - BITS - 1);
  localparam logic [3:0] TOP_BIT     = 4'(BITS - 1);

  seq_state_t state;
  logic [5:0] tickCount;
  logic [3:0] bitIdx;

  always_ff @(posedge clock) begin
    if (!rst_n || abort) begin
      state     <= SEQ_IDLE;
      tickCount <= 6'h00;
      bitIdx    <= 4'h0;
      dacCode   <= '0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        SEQ_IDLE: begin
          if (start) begin
            state     <= SEQ_SAMPLE;
            tickCount <= 6'h00;
            dacCode   <= '0;
          end
        end
        SEQ_SAMPLE: begin
          if (tick) begin
            tickCount <= tickCount + 6'h01;
            if (tickCount == SAMPLE_LAST) begin
              state            <= SEQ_DECIDE;
              bitIdx           <= TOP_BIT;
              dacCode          <= '0;
              dacCode[TOP_BIT] <= 1'b1;
            end
          end
        end
        SEQ_DECIDE: begin
          if (tick) begin
            dacCode[bitIdx] <= compHigh;
            if (bitIdx != 4'h0) begin
              dacCode[bitIdx - 4'h1] <= 1'b1;
              bitIdx <= bitIdx - 4'h1;
            end else begin
              state <= SEQ_IDLE;
              done  <= 1'b1;
            end
          end
        end
        default: state <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      result <= '0;
    end else if (state == SEQ_DECIDE && tick && bitIdx == 4'h0) begin
      result <= {dacCode[BITS-1:1], compHigh};
    end
  end

  assign busy     = (state != SEQ_IDLE);
  assign sampling = (state == SEQ_SAMPLE);
endmodule
`default_nettype wire

/* File: rtl/trigger_select.sv */
// Synchronises the hardware trigger events and picks one rising edge.
// Assumes event lines are asynchronous levels from other blocks or pins.
`timescale 1ns/10ps
`default_nettype none
module trigger_select #(
  parameter int SOURCES = 8
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // Events and selection
  input  wire logic [SOURCES-1:0] events,
  input  wire logic [2:0]         sourceSelect,
  input  wire logic               enable,
  // Start request
  output logic                    fire
);
  logic [SOURCES-1:0] syncFirst;
  logic [SOURCES-1:0] syncSecond;
  logic [SOURCES-1:0] syncPrev;

  genvar i;
  generate
    for (i = 0; i < SOURCES; i++) begin : g_sync
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          syncFirst[i]  <= 1'b0;
          syncSecond[i] <= 1'b0;
          syncPrev[i]   <= 1'b0;
        end else begin
          syncFirst[i]  <= events[i];
          syncSecond[i] <= syncFirst[i];
          syncPrev[i]   <= syncSecond[i];
        end
      end
    end
  endgenerate

  // Edge on the chosen source, only while enabled
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fire <= 1'b0;
    end else begin
      fire <= enable && syncSecond[sourceSelect] && !syncPrev[sourceSelect];
    end
  end
endmodule
`default_nettype wire

/* File: rtl/sar_adc_control_regs.sv */
// Register file and control of the 12-bit successive-approximation converter.
// Assumes an APB master on the same clock and an analog core outside.
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_regs #(
  parameter int CLK_DIV = sar_adc_pkg::CONV_CLK_DIV
) (
  // Clock and reset
  input  wire logic                            clock,
  input  wire logic                            rst_n,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [sar_adc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                     pwdata,
  output logic                                 pready,
  output logic [31:0]                          prdata,
  output logic                                 pslverr,
  // Analog core
  input  wire logic                            compRaw,
  output sar_adc_pkg::analog_ctrl_t            analogCtrl,
  // Hardware trigger events
  input  wire logic [sar_adc_pkg::TRIG_SOURCES-1:0] triggerEvents
);
  import sar_adc_pkg::*;

  localparam logic [7:0] DIV_LAST = 8'(CLK_DIV - 1);

  // Register state: control fields, second config and results
  logic       standby;
  logic       go;
  logic       reference_select;
  logic       doneFlag;
  logic [3:0] channel;
  logic [7:0] config2;
  logic [7:0] resultHigh;
  logic [7:0] resultLow;

  // Bus decode
  logic       access;
  logic       writeTaken;
  logic       aligned;
  logic [7:0] regIdx;
  logic       hitControl;
  logic       hitShared;
  logic       hitLow;
  logic       hitAny;
  logic [7:0] readValue;

  // Converter timing and sequencing
  logic [7:0] divCount;
  logic       tick;
  logic       compFirst;
  logic       compHigh;
  logic       startReq;
  logic       abortReq;
  logic       hwFire;
  logic       seqBusy;
  logic       seqSampling;
  logic       seqDone;
  logic [RESULT_BITS-1:0] seqResult;
  logic [RESULT_BITS-1:0] seqDac;
  logic       swStart;
  logic       swStop;

  assign access     = psel && penable;
  assign writeTaken = access && pready && pwrite;
  assign aligned    = (paddr[1:0] == 2'b00);
  assign regIdx     = 8'(paddr[ADDR_W-1:2]);
  assign hitControl = aligned && regIdx == IDX_CONTROL;
  assign hitShared  = aligned && regIdx == IDX_SHARED;
  assign hitLow     = aligned && regIdx == IDX_LOW;
  assign hitAny     = hitControl || hitShared || hitLow;

  assign swStart = writeTaken && hitControl && pwdata[CTL_GO];
  assign swStop  = writeTaken && hitControl && !pwdata[CTL_GO];

  // Read mux; shared slot shows config while in standby
  always_comb begin
    readValue = 8'h00;
    if (hitControl) begin
      readValue = {standby, go, reference_select, doneFlag, channel};
    end else if (hitShared) begin
      readValue = standby ? config2 : resultHigh;
    end else if (hitLow) begin
      readValue = resultLow;
    end
  end

  // APB answer after one wait state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access && !pready;
      if (access && !pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, readValue};
        pslverr <= !hitAny;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Control register fields
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      standby <= CONTROL_RESET[CTL_STANDBY];
      reference_select  <= CONTROL_RESET[CTL_REF];
      channel <= CONTROL_RESET[CTL_CH_LSB +: 4];
    end else if (writeTaken && hitControl) begin
      standby <= pwdata[CTL_STANDBY];
      reference_select  <= pwdata[CTL_REF];
      channel <= pwdata[CTL_CH_LSB +: 4];
    end
  end

  // Go bit: set by software or trigger, cleared on stop or finish
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      go <= CONTROL_RESET[CTL_GO];
    end else if (swStop || standby) begin
      go <= 1'b0;
    end else if (swStart || hwFire) begin
      go <= 1'b1;
    end else if (seqDone) begin
      go <= 1'b0;
    end
  end

  // Start and abort pulses to the sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      startReq <= 1'b0;
      abortReq <= 1'b0;
    end else begin
      startReq <= !standby && (swStart || hwFire);
      abortReq <= swStop || standby;
    end
  end

  // Done flag; a finish in the same cycle as a start wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      doneFlag <= CONTROL_RESET[CTL_DONE];
    end else if (seqDone) begin
      doneFlag <= 1'b1;
    end else if (startReq) begin
      doneFlag <= 1'b0;
    end
  end

  // Second config register, written at the shared slot
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      config2 <= CONFIG_RESET;
    end else if (writeTaken && hitShared) begin
      config2 <= pwdata[7:0];
    end
  end

  // Results loaded together, placed by alignment
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      resultHigh <= RESULT_RESET;
      resultLow  <= RESULT_RESET;
    end else if (seqDone) begin
      if (!config2[CFG_ALIGN]) begin
        resultHigh <= seqResult[11:4];
        resultLow  <= {seqResult[3:0], 4'h0};
      end else begin
        resultHigh <= {4'h0, seqResult[11:8]};
        resultLow  <= seqResult[7:0];
      end
    end
  end

  // Converter clock divider, halted in standby
  always_ff @(posedge clock) begin
    if (!rst_n || standby) begin
      divCount <= 8'h00;
      tick     <= 1'b0;
    end else begin
      tick     <= (divCount == DIV_LAST);
      divCount <= (divCount == DIV_LAST) ? 8'h00 : divCount + 8'h01;
    end
  end

  // Comparator level from the analog side
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      compFirst <= 1'b0;
      compHigh  <= 1'b0;
    end else begin
      compFirst <= compRaw;
      compHigh  <= compFirst;
    end
  end

  sar_sequencer #(
    .BITS   (RESULT_BITS),
    .CYCLES (CONV_CYCLES)
  ) u_sequencer (
    .clock    (clock),
    .rst_n    (rst_n),
    .tick     (tick),
    .start    (startReq),
    .abort    (abortReq),
    .compHigh (compHigh),
    .busy     (seqBusy),
    .sampling (seqSampling),
    .done     (seqDone),
    .result   (seqResult),
    .dacCode  (seqDac)
  );

  trigger_select #(
    .SOURCES (TRIG_SOURCES)
  ) u_trigger (
    .clock        (clock),
    .rst_n        (rst_n),
    .events       (triggerEvents),
    .sourceSelect (config2[CFG_TSEL +: 3]),
    .enable       (config2[CFG_HWTRIG] && !standby && !seqBusy),
    .fire         (hwFire)
  );

  // Analog controls, all from flip-flops
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      analogCtrl.powerDown       <= CONTROL_RESET[CTL_STANDBY];
      analogCtrl.referenceSelect <= CONTROL_RESET[CTL_REF];
      analogCtrl.inputEnable     <= 1'b1;
      analogCtrl.channelSelect   <= CH_INTERNAL_1V8;
      analogCtrl.sampling        <= 1'b0;
      analogCtrl.dacCode         <= '0;
    end else begin
      analogCtrl.powerDown       <= standby;
      analogCtrl.referenceSelect <= reference_select;
      analogCtrl.inputEnable     <= !(reference_select && channel == 4'h0);
      analogCtrl.channelSelect   <= channel;
      analogCtrl.sampling        <= seqSampling;
      analogCtrl.dacCode         <= seqDac;
    end
  end
endmodule
`default_nettype wire

/* File: verification/sar_adc_control_properties.sv */
// Port-level checker of the converter register block.
// Assumes one clock domain and the APB timing of the register block.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_properties
  import sar_adc_pkg::*;
#(
  parameter int CLK_DIV = 4
) (
  input wire logic                            clock,
  input wire logic                            rst_n,
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [sar_adc_pkg::ADDR_W-1:0]  paddr,
  input wire logic [31:0]                     pwdata,
  input wire logic                            pready,
  input wire logic [31:0]                     prdata,
  input wire logic                            pslverr,
  input wire logic                            compRaw,
  input wire sar_adc_pkg::analog_ctrl_t       analogCtrl,
  input wire logic [sar_adc_pkg::TRIG_SOURCES-1:0] triggerEvents
);
  localparam logic [ADDR_W-1:0] A_CTL = ADDR_W'({IDX_CONTROL, 2'b00});
  localparam logic [ADDR_W-1:0] A_SH  = ADDR_W'({IDX_SHARED, 2'b00});
  localparam logic [ADDR_W-1:0] A_LO  = ADDR_W'({IDX_LOW, 2'b00});
  logic       wr;
  logic       rdx;
  logic [7:0] ctl;
  logic [7:0] cfg;
  int         sampLen;
  assign wr  = psel && penable && pready && pwrite;
  assign rdx = psel && penable && pready && !pwrite;
  // Shadow copies of the written control and config bytes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctl <= CONTROL_RESET;
      cfg <= CONFIG_RESET;
    end else if (wr && paddr == A_CTL) begin
      ctl <= pwdata[7:0];
    end else if (wr && paddr == A_SH) begin
      cfg <= pwdata[7:0];
    end
  end
  // Length of the current sample phase
  always_ff @(posedge clock) begin
    if (!rst_n || !analogCtrl.sampling) begin
      sampLen <= 0;
    end else begin
      sampLen <= sampLen + 1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ready_after_access: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_rdata_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_slverr_unmapped: assert property (pready |-> pslverr == !(paddr == A_CTL
    || paddr == A_SH || paddr == A_LO))
    else $error("pslverr wrong for address");
  a_control_readback: assert property (rdx && paddr == A_CTL |-> prdata[7] == ctl[7]
    && prdata[5] == ctl[5] && prdata[3:0] == ctl[3:0])
    else $error("control read differs");
  a_shared_config: assert property (rdx && paddr == A_SH && ctl[7] |->
    prdata[7:0] == cfg)
    else $error("shared read not config in standby");
  a_control_drive: assert property (wr && paddr == A_CTL |-> ##2
    (analogCtrl.powerDown == ctl[7] && analogCtrl.referenceSelect == ctl[5]
    && analogCtrl.channelSelect == ctl[3:0]))
    else $error("analog control not following register");
  a_standby_idle: assert property (analogCtrl.powerDown [*3] |-> !analogCtrl.sampling)
    else $error("sampling in standby");
  a_sample_bound: assert property (sampLen <= 49 * CLK_DIV)
    else $error("sample phase too long");
endmodule
bind sar_adc_control_regs sar_adc_control_properties #(.CLK_DIV(CLK_DIV)) props (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .compRaw(compRaw), .analogCtrl(analogCtrl),
  .triggerEvents(triggerEvents));
`default_nettype wire

/* File: verification/analog_core_model.sv */
// Behavioural analog core: fixed channel levels and a comparator.
// Assumes the control struct of the register block on one clock.
`timescale 1ns/10ps
`default_nettype none
module analog_core_model
  import sar_adc_pkg::*;
(
  input  wire logic                      clock,
  input  wire sar_adc_pkg::analog_ctrl_t analogCtrl,
  output logic                           compRaw
);
  logic [11:0] level;
  logic        noise;
  initial noise = 1'b0;
  // Each channel has its own fixed level
  assign level = {analogCtrl.channelSelect, 8'h5A};
  always @(posedge clock) begin
    noise <= !noise;
  end
  // Powered down or input cut off: output toggles
  always_comb begin
    if (analogCtrl.powerDown || !analogCtrl.inputEnable) begin
      compRaw = noise;
    end else begin
      compRaw = (level >= analogCtrl.dacCode);
    end
  end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench of the converter register block over APB.
// Assumes the analog core model on the far side.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sar_adc_pkg::*;
  logic                    clock, rst_n, psel, penable, pwrite;
  logic                    pready, pslverr, compRaw, er, sawSample;
  logic [ADDR_W-1:0]       paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic [TRIG_SOURCES-1:0] triggerEvents;
  analog_ctrl_t            analogCtrl;
  int                      bad_count, tests_run, cycles;
  sar_adc_control_regs uut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .compRaw(compRaw),
    .analogCtrl(analogCtrl), .triggerEvents(triggerEvents));
  analog_core_model core (.clock(clock), .analogCtrl(analogCtrl), .compRaw(compRaw));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ADDR_W'({idx, 2'b00});
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic waitDone();
    int n;
    n = 0;
    do begin
      apb(1'b0, IDX_CONTROL, 8'h00);
      n++;
    end while (rd[CTL_DONE] !== 1'b1 && n < 200);
    chk("done flag", {31'h0, rd[CTL_DONE]}, 32'h00000001);
  endtask
  task automatic chkResult(input logic [3:0] c, input logic right);
    logic [11:0] v;
    v = {c, 8'h5A};
    apb(1'b0, IDX_LOW, 8'h00);
    chk("result low", rd, right ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0});
    apb(1'b0, IDX_SHARED, 8'h00);
    chk("result high", rd, right ? {28'h0, v[11:8]} : {24'h0, v[11:4]});
  endtask
  task automatic test_reset();
    apb(1'b0, IDX_CONTROL, 8'h00);
    chk("control", rd, 32'h0000008F);
    apb(1'b0, IDX_SHARED, 8'h00);
    chk("config", rd, 32'h00000001);
    apb(1'b0, 8'h9D, 8'h00);
    chk("unmapped error", {31'h0, er}, 32'h00000001);
    chk("power down", {31'h0, analogCtrl.powerDown}, 32'h00000001);
    $display("test reset done");
  endtask
  task automatic test_left();
    apb(1'b1, IDX_SHARED, 8'h01);
    apb(1'b1, IDX_CONTROL, 8'h0F);
    apb(1'b1, IDX_CONTROL, 8'h4F);
    waitDone(); // First result after standby is discarded
    apb(1'b1, IDX_CONTROL, 8'h4F);
    waitDone();
    chk("control done", rd, 32'h0000001F);
    chkResult(4'hF, 1'b0);
    apb(1'b1, IDX_LOW, 8'hFF);
    chkResult(4'hF, 1'b0);
    $display("test left done");
  endtask
  task automatic test_right_abort();
    apb(1'b1, IDX_SHARED, 8'h05);
    apb(1'b1, IDX_CONTROL, 8'h43);
    waitDone();
    chkResult(4'h3, 1'b1);
    apb(1'b1, IDX_CONTROL, 8'h46);
    repeat (30) @(posedge clock);
    apb(1'b1, IDX_CONTROL, 8'h06);
    repeat (300) @(posedge clock);
    apb(1'b0, IDX_CONTROL, 8'h00);
    chk("control after stop", rd, 32'h00000006);
    chkResult(4'h3, 1'b1);
    $display("test right and stop done");
  endtask
  task automatic pulse(input int s);
    sawSample <= 1'b0;
    triggerEvents <= TRIG_SOURCES'(1 << s);
    repeat (6) @(posedge clock);
    triggerEvents <= '0;
    repeat (40) @(posedge clock);
  endtask
  task automatic test_trigger();
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, IDX_SHARED, 8'h84 | 8'(s << CFG_TSEL));
      apb(1'b1, IDX_CONTROL, 8'(s + 4));
      pulse(s ^ 1);
      chk("wrong source", {31'h0, sawSample}, 32'h0);
      pulse(s);
      waitDone();
      chkResult(4'(s + 4), 1'b1);
    end
    apb(1'b1, IDX_SHARED, 8'h04);
    pulse(0);
    chk("trigger disabled", {31'h0, sawSample}, 32'h0);
    $display("test trigger done");
  endtask
  task automatic test_standby();
    apb(1'b1, IDX_CONTROL, 8'hE5);
    apb(1'b0, IDX_CONTROL, 8'h00);
    chk("control standby", rd & 32'hEF, 32'h000000A5);
    chk("analog", {25'h0, analogCtrl.powerDown, analogCtrl.referenceSelect,
      analogCtrl.inputEnable, analogCtrl.channelSelect}, 32'h00000075);
    apb(1'b1, IDX_CONTROL, 8'hA0);
    apb(1'b0, IDX_CONTROL, 8'h00);
    chk("input cut", {25'h0, analogCtrl.powerDown, analogCtrl.referenceSelect,
      analogCtrl.inputEnable, analogCtrl.channelSelect}, 32'h00000060);
    apb(1'b0, IDX_SHARED, 8'h00);
    chk("config in standby", rd, 32'h00000004);
    $display("test standby done");
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (analogCtrl.sampling === 1'b1) begin
      sawSample <= 1'b1;
    end
    if (cycles == 40000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite, sawSample} = '0;
    paddr = '0;
    pwdata = '0;
    triggerEvents = '0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    test_reset();
    test_left();
    test_right_abort();
    test_trigger();
    test_standby();
    report_and_stop();
  end
endmodule
`default_nettype wire
